/* File: src/rtc_pkg.sv */
/*
 * Shared constants of the real-time-clock counter chain: register byte
 * offsets, field positions, reset values and stage limits.
 * Assumes a 16-bit register port with byte addresses on an 8-bit bus.
 */
`default_nettype none

package rtc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_CLKCFG    = 8'h04;
    localparam logic [7:0] OFF_PTMR      = 8'h08;
    localparam logic [7:0] OFF_PTMR_REL  = 8'h0C;
    localparam logic [7:0] OFF_CHAIN_LO  = 8'h10;
    localparam logic [7:0] OFF_CHAIN_HI  = 8'h14;
    localparam logic [7:0] OFF_REL_LO    = 8'h18;
    localparam logic [7:0] OFF_REL_HI    = 8'h1C;

    // Control register fields
    localparam int CTRL_RUN_BIT     = 0;
    localparam int CTRL_PRE8_BIT    = 1;
    localparam int CTRL_DEC_BIT     = 2;
    localparam int CTRL_INC_BIT     = 3;
    localparam int CTRL_DIV32OFF_BIT = 4;
    localparam int CTRL_ACC_BIT     = 15;

    // Clock configuration register fields
    localparam int CLK_SEL_LSB      = 0;
    localparam int CLK_SEL_W        = 2;
    localparam int CLK_MODE_BIT     = 2;
    localparam int NUM_SRC          = 4;

    // Reset values
    localparam logic [15:0] CTRL_RST   = 16'h8003;
    localparam logic [15:0] CLKCFG_RST = 16'h0006;
    localparam logic [15:0] PTMR_RST   = 16'h0000;
    localparam logic [31:0] CHAIN_RST  = 32'h0000_0000;

    // Stage limits
    localparam logic [15:0] PTMR_MAX   = 16'hFFFF;
    localparam logic [4:0]  DIV32_MAX  = 5'h1F;
    localparam logic [2:0]  DIV8_MAX   = 3'h7;
    localparam logic [9:0]  MAX_10     = 10'h3FF;
    localparam logic [9:0]  MAX_6      = 10'h03F;

    // Least ratio of system clock to count clock for clean synchronisation
    localparam int SYNC_RATIO_MIN = 4;

endpackage

`default_nettype wire

/* File: src/rtc_timebase.sv */
/*
 * Real-time-clock time base: source select, 32:1 and 8:1 prescalers,
 * reloadable 16-bit prescale timer, 32-bit chain of four reloadable
 * counters, pulse correction and clocking-mode handshake.
 * Assumes the count sources are asynchronous levels and that nrst_i
 * is the power reset only; other resets must not reach this block.
 */
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module rtc_timebase
(
    // Clock and power reset
    input  wire logic                         core_clk_i,
    input  wire logic                         nrst_i,
    // Count clock sources
    input  wire logic [rtc_pkg::NUM_SRC-1:0]  count_src_i,
    // Register port
    input  wire logic [7:0]                   addr_i,
    input  wire logic [15:0]                  wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [15:0]                  rdata_o,
    // Interrupt requests
    output logic      [4:0]                   timer_irq_o,
    output logic                              irq_o
);

    typedef struct packed {
        logic                        run;
        logic                        pre8;
        logic                        dec;
        logic                        inc;
        logic                        div32_off;
        logic                        mode;
        logic [rtc_pkg::CLK_SEL_W-1:0] sel;
        logic                        acc;
        logic                        extra;
        logic [rtc_pkg::NUM_SRC-1:0] sync1;
        logic [rtc_pkg::NUM_SRC-1:0] sync2;
        logic                        prev;
        logic [4:0]                  div32;
        logic [2:0]                  div8;
        logic [15:0]                 ptmr;
        logic [15:0]                 ptmr_rel;
        logic [31:0]                 chain;
        logic [31:0]                 rel;
        logic [4:0]                  irq_req;
        logic                        irq;
        logic [15:0]                 rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic       sel_lvl;
    logic       sel_edge;
    logic       e32;
    logic       count_ev;
    logic       tick;
    logic       ovf_ptmr;
    logic [3:0] ovf;
    logic [9:0] st_val [4];
    logic       wr_ok;

    // One counter stage of up to 10 bits: count up, reload on overflow
    function automatic logic [10:0] stage_step(input logic       en,
                                               input logic [9:0] v,
                                               input logic [9:0] r,
                                               input logic [9:0] vmax);
        logic [10:0] res;
        res = {1'b0, v};
        if (en)
        begin
            if (v == vmax)
                res = {1'b1, r};
            else
                res = {1'b0, v + 10'h001};
        end
        return res;
    endfunction

    always_comb
    begin
        s_d = s_q;
        st_val[0] = '0;
        st_val[1] = '0;
        st_val[2] = '0;
        st_val[3] = '0;
        ovf       = '0;
        ovf_ptmr  = 1'b0;
        tick      = 1'b0;

        // Every source is synchronised; the mux reads only second stages
        s_d.sync1 = count_src_i;
        s_d.sync2 = s_q.sync1;
        sel_lvl   = s_q.sync2[s_q.sel];
        s_d.prev  = sel_lvl;
        sel_edge  = sel_lvl & ~s_q.prev;

        // Input prescalers
        e32 = 1'b0;
        if (s_q.run && sel_edge)
        begin
            if (s_q.div32_off)
                e32 = 1'b1;
            else
            begin
                s_d.div32 = s_q.div32 + 5'h01;
                e32 = (s_q.div32 == rtc_pkg::DIV32_MAX);
            end
        end
        count_ev = 1'b0;
        if (e32)
        begin
            if (!s_q.pre8)
                count_ev = 1'b1;
            else
            begin
                s_d.div8 = s_q.div8 + 3'h1;
                count_ev = (s_q.div8 == rtc_pkg::DIV8_MAX);
            end
        end

        // Pulse correction; the extra pulse follows one cycle later
        s_d.extra = 1'b0;
        if (count_ev)
        begin
            if (s_q.inc && s_q.dec)
            begin
                tick      = 1'b1;
                s_d.inc   = 1'b0;
                s_d.dec   = 1'b0;
            end
            else if (s_q.dec)
                s_d.dec   = 1'b0;
            else if (s_q.inc)
            begin
                tick      = 1'b1;
                s_d.extra = 1'b1;
                s_d.inc   = 1'b0;
            end
            else
                tick      = 1'b1;
        end
        if (s_q.extra)
            tick = 1'b1;

        // Prescale timer
        if (tick)
        begin
            if (s_q.ptmr == rtc_pkg::PTMR_MAX)
            begin
                s_d.ptmr = s_q.ptmr_rel;
                ovf_ptmr = 1'b1;
            end
            else
                s_d.ptmr = s_q.ptmr + 16'h0001;
        end

        // 32-bit block fed by prescale timer overflows
        {ovf[0], st_val[0]} = stage_step(ovf_ptmr, s_q.chain[9:0],
                                         s_q.rel[9:0], rtc_pkg::MAX_10);
        {ovf[1], st_val[1]} = stage_step(ovf[0], {4'h0, s_q.chain[15:10]},
                                         {4'h0, s_q.rel[15:10]}, rtc_pkg::MAX_6);
        {ovf[2], st_val[2]} = stage_step(ovf[1], {4'h0, s_q.chain[21:16]},
                                         {4'h0, s_q.rel[21:16]}, rtc_pkg::MAX_6);
        {ovf[3], st_val[3]} = stage_step(ovf[2], s_q.chain[31:22],
                                         s_q.rel[31:22], rtc_pkg::MAX_10);
        s_d.chain = {st_val[3], st_val[2][5:0], st_val[1][5:0], st_val[0]};

        s_d.irq_req = {ovf, ovf_ptmr};
        s_d.irq     = |s_d.irq_req;

        // The new mode counts as established on a count-clock edge
        if (sel_edge)
            s_d.acc = s_q.mode;

        // Register writes; they win over hardware updates of the same cycle
        wr_ok = wr_i & s_q.acc;
        if (wr_i && addr_i == rtc_pkg::OFF_CLKCFG)
        begin
            s_d.sel  = wdata_i[rtc_pkg::CLK_SEL_LSB +: rtc_pkg::CLK_SEL_W];
            // Both modes share one sync path, so a switch drops no count edge
            s_d.mode = wdata_i[rtc_pkg::CLK_MODE_BIT];
        end
        if (wr_ok)
        begin
            unique case (addr_i)
                rtc_pkg::OFF_CTRL:
                begin
                    s_d.run       = wdata_i[rtc_pkg::CTRL_RUN_BIT];
                    s_d.pre8      = wdata_i[rtc_pkg::CTRL_PRE8_BIT];
                    s_d.dec       = wdata_i[rtc_pkg::CTRL_DEC_BIT];
                    s_d.inc       = wdata_i[rtc_pkg::CTRL_INC_BIT];
                    s_d.div32_off = wdata_i[rtc_pkg::CTRL_DIV32OFF_BIT];
                end
                rtc_pkg::OFF_PTMR:     s_d.ptmr        = wdata_i;
                rtc_pkg::OFF_PTMR_REL: s_d.ptmr_rel    = wdata_i;
                rtc_pkg::OFF_CHAIN_LO: s_d.chain[15:0] = wdata_i;
                rtc_pkg::OFF_CHAIN_HI: s_d.chain[31:16] = wdata_i;
                rtc_pkg::OFF_REL_LO:   s_d.rel[15:0]   = wdata_i;
                rtc_pkg::OFF_REL_HI:   s_d.rel[31:16]  = wdata_i;
                default:               s_d.run         = s_q.run;
            endcase
        end

        // Read data stand for exactly one cycle
        s_d.rdata = 16'h0000;
        if (rd_i)
        begin
            unique case (addr_i)
                rtc_pkg::OFF_CTRL:
                begin
                    s_d.rdata[rtc_pkg::CTRL_RUN_BIT]      = s_q.run;
                    s_d.rdata[rtc_pkg::CTRL_PRE8_BIT]     = s_q.pre8;
                    s_d.rdata[rtc_pkg::CTRL_DEC_BIT]      = s_q.dec;
                    s_d.rdata[rtc_pkg::CTRL_INC_BIT]      = s_q.inc;
                    s_d.rdata[rtc_pkg::CTRL_DIV32OFF_BIT] = s_q.div32_off;
                    s_d.rdata[rtc_pkg::CTRL_ACC_BIT]      = s_q.acc;
                end
                rtc_pkg::OFF_CLKCFG:
                begin
                    s_d.rdata[rtc_pkg::CLK_SEL_LSB +: rtc_pkg::CLK_SEL_W] = s_q.sel;
                    s_d.rdata[rtc_pkg::CLK_MODE_BIT] = s_q.mode;
                end
                rtc_pkg::OFF_PTMR:     s_d.rdata = s_q.ptmr;
                rtc_pkg::OFF_PTMR_REL: s_d.rdata = s_q.ptmr_rel;
                rtc_pkg::OFF_CHAIN_LO: s_d.rdata = s_q.chain[15:0];
                rtc_pkg::OFF_CHAIN_HI: s_d.rdata = s_q.chain[31:16];
                rtc_pkg::OFF_REL_LO:   s_d.rdata = s_q.rel[15:0];
                rtc_pkg::OFF_REL_HI:   s_d.rdata = s_q.rel[31:16];
                default:               s_d.rdata = 16'h0000;
            endcase
        end
    end

    // Power reset is the only reset of this block
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            s_q           <= '0;
            s_q.run       <= rtc_pkg::CTRL_RST[rtc_pkg::CTRL_RUN_BIT];
            s_q.pre8      <= rtc_pkg::CTRL_RST[rtc_pkg::CTRL_PRE8_BIT];
            s_q.div32_off <= rtc_pkg::CTRL_RST[rtc_pkg::CTRL_DIV32OFF_BIT];
            s_q.acc       <= rtc_pkg::CTRL_RST[rtc_pkg::CTRL_ACC_BIT];
            s_q.mode      <= rtc_pkg::CLKCFG_RST[rtc_pkg::CLK_MODE_BIT];
            s_q.sel       <= rtc_pkg::CLKCFG_RST[rtc_pkg::CLK_SEL_LSB +: rtc_pkg::CLK_SEL_W];
            s_q.ptmr      <= rtc_pkg::PTMR_RST;
            s_q.chain     <= rtc_pkg::CHAIN_RST;
        end
        else
            s_q <= s_d;
    end

    assign rdata_o     = s_q.rdata;
    assign timer_irq_o = s_q.irq_req;
    assign irq_o       = s_q.irq;

    chk_reset_values: assert property (@(posedge core_clk_i)
        $rose(nrst_i) |-> (s_q.run && s_q.pre8 && !s_q.div32_off && s_q.acc && s_q.mode))
        else $error("control state wrong after power reset");

    chk_async_write_block: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (!s_q.acc && wr_i && addr_i == rtc_pkg::OFF_PTMR_REL)
        |=> (s_q.ptmr_rel == $past(s_q.ptmr_rel)))
        else $error("register written while access restricted");

    chk_sync_write_ok: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.acc && wr_i && addr_i == rtc_pkg::OFF_PTMR_REL)
        |=> (s_q.ptmr_rel == $past(wdata_i)))
        else $error("register write lost while access allowed");

    chk_mode_handshake: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (sel_edge && s_q.acc != s_q.mode) |=> (s_q.acc == $past(s_q.mode)))
        else $error("access flag did not follow clock mode");

    chk_dec_suppress: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (count_ev && s_q.dec && !s_q.inc && !wr_i && !s_q.extra)
        |=> (!s_q.dec && s_q.ptmr == $past(s_q.ptmr)))
        else $error("count event not suppressed");

    chk_inc_adds: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (count_ev && s_q.inc && !s_q.dec && !wr_i && s_q.ptmr < 16'hFFFE ##1 !wr_i)
        |=> (s_q.ptmr == $past(s_q.ptmr, 2) + 16'h0002))
        else $error("extra count pulse missing");

    chk_both_cancel: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (count_ev && s_q.inc && s_q.dec && !wr_i && s_q.ptmr != rtc_pkg::PTMR_MAX)
        |=> (s_q.ptmr == $past(s_q.ptmr) + 16'h0001 && !s_q.inc && !s_q.dec))
        else $error("both corrections changed the count");

    chk_prescale_reload: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (tick && s_q.ptmr == rtc_pkg::PTMR_MAX && !wr_i)
        |=> (s_q.ptmr == $past(s_q.ptmr_rel) && s_q.irq_req[0] && s_q.irq))
        else $error("prescale timer overflow mishandled");

    chk_stage_reload: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (ovf[0] && !wr_i)
        |=> (s_q.chain[9:0] == $past(s_q.rel[9:0]) && s_q.irq_req[1] && s_q.irq))
        else $error("first chain stage overflow mishandled");

    chk_count_up: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (tick && s_q.ptmr != rtc_pkg::PTMR_MAX && !wr_i)
        |=> (s_q.ptmr == $past(s_q.ptmr) + 16'h0001))
        else $error("prescale timer did not count up");

    chk_stop_holds: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (!s_q.run && !s_q.extra && !wr_i) |=> (s_q.ptmr == $past(s_q.ptmr)))
        else $error("timer moved while stopped");

    chk_stop_prescalers: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (!s_q.run && !wr_i)
        |=> (s_q.div32 == $past(s_q.div32) && s_q.div8 == $past(s_q.div8)))
        else $error("prescaler moved while stopped");

endmodule

`default_nettype wire

/* File: tb/count_source_model.sv */
/*
 * Model of the count clock sources that feed the time base.
 * Assumes it shares the system clock with the block and that the
 * caller asks for one burst at a time.
 */
`timescale 1ns/100ps
`default_nettype none

module count_source_model
#(
    parameter int HALF = 3
)
(
    // System clock
    input  wire logic      clk_i,
    // Count clock sources
    output var logic [3:0] src_o
);
    initial src_o = 4'h0;

    // Sources rest low between bursts, so no stray edge reaches the chain
    task automatic emit(input int idx, input int n);
        repeat (n)
        begin
            repeat (HALF) @(posedge clk_i);
            src_o[idx] <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            src_o[idx] <= 1'b0;
        end
        // Room for the two-flop sync and the overflow pulse to land
        repeat (4) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

/* File: tb/rtc_timebase_tb.sv */
/*
 * Self-checking bench of the time base: register port tasks and
 * directed sequences of reads, writes and count bursts.
 * Assumes the register map of the shared package and a single clock.
 */
`timescale 1ns/100ps
`default_nettype none

module rtc_timebase_tb;
    logic        core_clk_i = 1'b0;
    logic        nrst_i     = 1'b0;
    logic [3:0]  src;
    logic [7:0]  addr_i     = 8'h00;
    logic [15:0] wdata_i    = 16'h0000;
    logic        wr_i       = 1'b0;
    logic        rd_i       = 1'b0;
    logic [15:0] rdata_o;
    logic [4:0]  timer_irq_o;
    logic        irq_o;
    logic [15:0] v;
    int          num_errors = 0;
    int          n_compared = 0;
    int          irq_cnt [5];
    int          pre_ctrl [3] = '{32'h13, 32'h01, 32'h03};
    int          pre_n [3]    = '{16, 64, 512};

    always #5 core_clk_i = ~core_clk_i;

    rtc_timebase dut_u (
        .core_clk_i  (core_clk_i),
        .nrst_i      (nrst_i),
        .count_src_i (src),
        .addr_i      (addr_i),
        .wdata_i     (wdata_i),
        .wr_i        (wr_i),
        .rd_i        (rd_i),
        .rdata_o     (rdata_o),
        .timer_irq_o (timer_irq_o),
        .irq_o       (irq_o)
    );

    count_source_model src_u (
        .clk_i (core_clk_i),
        .src_o (src)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
        check(v, exp);
    endtask

    task automatic finish_test;
        $display("Mismatches %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge core_clk_i)
    begin
        if (nrst_i === 1'b1)
        begin
            check({15'h0, irq_o}, {15'h0, |timer_irq_o});
            for (int b = 0; b < 5; b++)
                if (timer_irq_o[b] === 1'b1)
                    irq_cnt[b]++;
        end
    end

    initial
    begin
        #200000;
        num_errors++;
        finish_test();
    end

    initial
    begin
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        rdc(8'h00, 16'h8003);
        rdc(8'h04, 16'h0006);
        rdc(8'h08, 16'h0000);
        rdc(8'h10, 16'h0000);
        rdc(8'h14, 16'h0000);
        rdc(8'h20, 16'h0000);
        // Full cascade: every chain stage at its top, prescale timer one below, nonzero reloads low
        wr(8'h00, 16'h0011);
        wr(8'h0C, 16'hFFF0);
        wr(8'h08, 16'hFFFE);
        wr(8'h10, 16'hFFFF);
        wr(8'h14, 16'hFFFF);
        wr(8'h18, 16'h0401);
        src_u.emit(2, 1);
        rdc(8'h08, 16'hFFFF);
        check(16'(irq_cnt[0]), 16'h0000);
        src_u.emit(2, 1);
        rdc(8'h08, 16'hFFF0);
        rdc(8'h10, 16'h0401);
        rdc(8'h14, 16'h0000);
        for (int b = 0; b < 5; b++)
            check(16'(irq_cnt[b]), 16'h0001);
        // Each of the three dividing prescaler settings over two whole divider periods
        wr(8'h0C, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h08, 16'h0000);
            wr(8'h00, 16'(pre_ctrl[i]));
            src_u.emit(2, pre_n[i]);
            rdc(8'h08, 16'h0002);
        end
        wr(8'h00, 16'h0010);
        wr(8'h08, 16'h0000);
        src_u.emit(2, 3);
        rdc(8'h08, 16'h0000);
        wr(8'h00, 16'h0019);
        src_u.emit(2, 1);
        rdc(8'h08, 16'h0002);
        rdc(8'h00, 16'h8011);
        wr(8'h00, 16'h0015);
        rdc(8'h00, 16'h8015);
        src_u.emit(2, 1);
        rdc(8'h08, 16'h0002);
        rdc(8'h00, 16'h8011);
        wr(8'h00, 16'h001D);
        src_u.emit(2, 1);
        rdc(8'h08, 16'h0003);
        rdc(8'h00, 16'h8011);
        // Only the selected source may count
        wr(8'h04, 16'h0004);
        src_u.emit(2, 2);
        rdc(8'h08, 16'h0003);
        src_u.emit(0, 2);
        rdc(8'h08, 16'h0005);
        // Source already chosen, then leave synchronous mode
        wr(8'h04, 16'h0000);
        src_u.emit(0, 1);
        rdc(8'h00, 16'h0011);
        wr(8'h08, 16'h5555);
        wr(8'h00, 16'h0000);
        wr(8'h0C, 16'h7777);
        repeat (3) rdc(8'h08, 16'h0006);
        src_u.emit(0, 1);
        rdc(8'h08, 16'h0007);
        wr(8'h04, 16'h0004);
        src_u.emit(0, 1);
        rdc(8'h00, 16'h8011);
        wr(8'h08, 16'h1234);
        rdc(8'h08, 16'h1234);
        rdc(8'h0C, 16'h0000);
        finish_test();
    end
endmodule

`default_nettype wire
